//--- inc/sbi_pkg.sv
// Constants and types for the four-bank SDRAM bank-state core.
// Assumes one 20 MHz clock shared by the command pins and the core.
package sbi_pkg;
  localparam int CLK_NS   = 50;
  localparam int T_RP_NS  = 20;
  localparam int T_RCD_NS = 20;
  localparam int T_WR_NS  = 15;
  localparam int T_XSR_NS = 75;

  // Least times round up to whole cycles, never below one
  function automatic logic [4:0] ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 5'h01 : 5'(c);
  endfunction : ns2cyc

  localparam logic [4:0] RP_CYC  = ns2cyc(T_RP_NS);
  localparam logic [4:0] RCD_CYC = ns2cyc(T_RCD_NS);
  localparam logic [4:0] WR_CYC  = ns2cyc(T_WR_NS);
  localparam logic [4:0] XSR_CYC = ns2cyc(T_XSR_NS);

  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;

  localparam int         NBANK    = 4;
  localparam int         AP_BIT   = 10;
  localparam int         BL_LSB   = 0;
  localparam int         CL_LSB   = 4;
  localparam logic [1:0] CL_RST   = 2'h2;
  localparam logic [2:0] BL_RST   = 3'h0;
  localparam logic [2:0] BL_FULL  = 3'h7;
  localparam int         WQ_DEPTH = 32;
  localparam int         WQ_W     = 46;

  typedef enum logic [7:0] {
    BK_IDLE = 8'h01, BK_ACTING = 8'h02, BK_ACTIVE = 8'h04, BK_READ = 8'h08,
    BK_WRITE = 8'h10, BK_RD_AP = 8'h20, BK_WR_AP = 8'h40, BK_PRECH = 8'h80
  } sbi_bank_t;

  typedef enum logic [2:0] {
    BU_NONE = 3'h1, BU_READ = 3'h2, BU_WRITE = 3'h4
  } sbi_burst_t;
endpackage : sbi_pkg

//--- inc/sbi_bank_if.sv
// Command strobes from the decoder to one bank, and that bank's state.
// All strobes but ap are one-cycle pulses on the core clock; ap follows address bit 10 every cycle.
`timescale 1ns/1ps
`default_nettype none
interface sbi_bank_if;
  import sbi_pkg::*;
  logic      act;
  logic      rd;
  logic      wr;
  logic      ap;
  logic      pre;
  logic      done;
  logic      intr;
  sbi_bank_t state;
  modport ctrl (output act, rd, wr, ap, pre, done, intr, input state);
  modport bank (input act, rd, wr, ap, pre, done, intr, output state);
endinterface : sbi_bank_if
`default_nettype wire

//--- rtl/sbi_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes the depth is a power of two so the pointers wrap on their own.
`timescale 1ns/1ps
`default_nettype none
module sbi_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         i_clock,
  input  wire logic         i_nrst,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  output logic              o_valid,
  output logic      [W-1:0] o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign o_ready = cnt_r != (AW+1)'(D);
  assign o_valid = cnt_r != '0;
  assign o_data  = mem[rp_r];

  always_comb begin
    push    = i_valid & o_ready;
    pop     = o_valid & i_ready;
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wp_r] <= i_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : sbi_fifo
`default_nettype wire

//--- rtl/sbi_bank.sv
// State of one SDRAM bank: idle, opening, open, bursting, precharging.
// Assumes the decoder sends only commands legal for this bank's state.
`timescale 1ns/1ps
`default_nettype none
module sbi_bank import sbi_pkg::*; (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  sbi_bank_if.bank  bif
);
  localparam int RCD_D = RCD_CYC;
  localparam int RP_D  = RP_CYC;
  sbi_bank_t  state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic       end_r, end_nxt;

  function automatic sbi_bank_t burst_state(input logic rd, input logic ap);
    if (rd) return ap ? BK_RD_AP : BK_READ;
    return ap ? BK_WR_AP : BK_WRITE;
  endfunction : burst_state

  assign bif.state = state_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != 5'h00) ? cnt_r - 5'h01 : cnt_r;
    end_nxt   = end_r;
    case (state_r)
      BK_IDLE: begin
        if (bif.act) begin
          state_nxt = BK_ACTING;
          cnt_nxt   = RCD_CYC;
        end
      end
      BK_ACTING: begin
        if (cnt_r == 5'h01) state_nxt = BK_ACTIVE;
      end
      BK_ACTIVE, BK_READ, BK_WRITE: begin
        if (bif.rd | bif.wr) begin
          state_nxt = burst_state(bif.rd, bif.ap);
        end else if (bif.pre) begin
          state_nxt = BK_PRECH;
          cnt_nxt   = RP_CYC;
        end else if (state_r != BK_ACTIVE && (bif.done | bif.intr)) begin
          state_nxt = BK_ACTIVE;
        end
      end
      BK_RD_AP, BK_WR_AP: begin
        // Write recovery runs from the interrupting command, then precharge_period
        if (!end_r && (bif.done | bif.intr)) begin
          end_nxt = 1'b1;
          cnt_nxt = (state_r == BK_RD_AP) ? RP_CYC : 5'(WR_CYC + RP_CYC);
        end else if (end_r && cnt_r == 5'h01) begin
          state_nxt = BK_IDLE;
          end_nxt   = 1'b0;
        end
      end
      BK_PRECH: begin
        if (cnt_r == 5'h01) state_nxt = BK_IDLE;
      end
      default: state_nxt = BK_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= BK_IDLE;
      cnt_r   <= 5'h00;
      end_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      end_r   <= end_nxt;
    end
  end

  chk_act_open_row: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (bif.act && state_r == BK_IDLE) |=>
      (state_r == BK_ACTING) ##RCD_D (state_r == BK_ACTIVE))
    else $error("bank not open after activate delay");

  chk_prech_to_idle: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    $rose(state_r == BK_PRECH) |-> ##RP_D (state_r == BK_IDLE))
    else $error("bank not idle after precharge period");
endmodule : sbi_bank
`default_nettype wire

//--- rtl/sbi_sdram_core.sv
// Command decoder, burst engine and data paths of a four-bank SDRAM.
// Assumes commands and DQ arrive on the core clock from a controller;
// stored data lives outside, behind the read port and the write queue.
`timescale 1ns/1ps
`default_nettype none
module sbi_sdram_core import sbi_pkg::*; (
  input  wire logic            i_clock,
  input  wire logic            i_nrst,
  input  wire logic            i_cke,
  input  wire logic            i_cs_n,
  input  wire logic            i_ras_n,
  input  wire logic            i_cas_n,
  input  wire logic            i_we_n,
  input  wire logic [1:0]      i_ba,
  input  wire logic [10:0]     i_addr,
  input  wire logic [3:0]      i_dqm,
  input  wire logic [31:0]     i_dq,
  output logic      [31:0]     o_dq,
  output logic                 o_dq_oe,
  output logic                 o_rd_req,
  output logic      [9:0]      o_rd_addr,
  input  wire logic [31:0]     i_rd_data,
  output logic                 o_wbuf_ready,
  output logic                 o_wq_valid,
  output logic      [WQ_W-1:0] o_wq_data,
  input  wire logic            i_wq_ready,
  output logic      [3:0]      o_bank_idle,
  output logic                 o_self_refresh
);
  localparam int RP_LAST = RP_CYC + 1;
  localparam int WR_HOLD = WR_CYC + RP_CYC;

  logic        cke_d_r, cke_d_nxt;
  logic        sref_r, sref_nxt;
  logic [4:0]  xsr_r, xsr_nxt;
  logic [1:0]  cl_r, cl_nxt;
  logic [2:0]  bl_r, bl_nxt;
  sbi_burst_t  bmode_r, bmode_nxt;
  logic [1:0]  bbank_r, bbank_nxt;
  logic [7:0]  bcol_r, bcol_nxt;
  logic [8:0]  left_r, left_nxt;
  logic        fp_r, fp_nxt;
  logic [2:0]  pv_r, pv_nxt;
  logic [31:0] pd_r [3];
  logic [31:0] pd_nxt [3];
  logic [3:0]  dqm_d_r [2];
  logic [3:0]  dqm_d_nxt [2];

  logic [2:0]  cmd;
  logic        live, all_idle;
  logic        is_act, is_rd, is_wr, is_pre, is_bst, is_lmr;
  logic        new_burst, beat, rbeat, wbeat, done_c, intr_c, stop_c;
  logic [9:0]  beat_addr;
  logic [1:0]  out_idx;

  function automatic logic [8:0] bl_beats(input logic [2:0] code);
    case (code)
      3'h0:    return 9'h001;
      3'h1:    return 9'h002;
      3'h2:    return 9'h004;
      3'h3:    return 9'h008;
      default: return 9'h100;
    endcase
  endfunction : bl_beats

  function automatic logic is_cmd(input logic [2:0] c, input logic [2:0] k);
    return c == k;
  endfunction : is_cmd

  // Command decode; a deselected or gated cycle acts as a no-operation
  assign cmd      = {i_ras_n, i_cas_n, i_we_n};
  assign live     = cke_d_r & i_cke & ~i_cs_n & ~sref_r
                  & (xsr_r == 5'h00);
  assign is_act   = live & is_cmd(cmd, CMD_ACT);
  assign is_rd    = live & is_cmd(cmd, CMD_RD);
  assign is_wr    = live & is_cmd(cmd, CMD_WR);
  assign is_pre   = live & is_cmd(cmd, CMD_PRE);
  assign is_bst   = live & is_cmd(cmd, CMD_BST);
  assign is_lmr   = live & is_cmd(cmd, CMD_LMR) & all_idle;
  assign all_idle = &o_bank_idle;

  // Clock enable history, self refresh and its exit delay
  always_comb begin
    cke_d_nxt = i_cke;
    sref_nxt  = sref_r;
    xsr_nxt   = (xsr_r != 5'h00) ? xsr_r - 5'h01 : xsr_r;
    if (!sref_r && cke_d_r && !i_cke && !i_cs_n && all_idle
        && is_cmd(cmd, CMD_REF)) begin
      sref_nxt = 1'b1;
    end else if (sref_r && i_cke) begin
      sref_nxt = 1'b0;
      xsr_nxt  = XSR_CYC;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cke_d_r <= 1'b0;
      sref_r  <= 1'b0;
      xsr_r   <= 5'h00;
    end else begin
      cke_d_r <= cke_d_nxt;
      sref_r  <= sref_nxt;
      xsr_r   <= xsr_nxt;
    end
  end

  // Mode register; reserved latency codes are ignored
  always_comb begin
    cl_nxt = cl_r;
    bl_nxt = bl_r;
    if (is_lmr && i_addr[CL_LSB +: 2] != 2'h0) begin
      cl_nxt = i_addr[CL_LSB +: 2];
      bl_nxt = i_addr[BL_LSB +: 3];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cl_r <= CL_RST;
      bl_r <= BL_RST;
    end else begin
      cl_r <= cl_nxt;
      bl_r <= bl_nxt;
    end
  end

  // Burst engine: one burst runs at a time; a new column command
  // replaces it, and the bank it came from hears of the cut if the new command is for another bank.
  assign stop_c = is_bst | (is_pre & (i_addr[AP_BIT] | i_ba == bbank_r));

  always_comb begin
    bmode_nxt = bmode_r;
    bbank_nxt = bbank_r;
    bcol_nxt  = bcol_r;
    left_nxt  = left_r;
    fp_nxt    = fp_r;
    new_burst = is_rd | is_wr;
    beat      = 1'b0;
    done_c    = 1'b0;
    intr_c    = 1'b0;
    if (new_burst) begin
      intr_c    = (bmode_r != BU_NONE) & (bbank_r != i_ba);
      bmode_nxt = is_rd ? BU_READ : BU_WRITE;
      bbank_nxt = i_ba;
      bcol_nxt  = i_addr[7:0] + 8'h01;
      left_nxt  = bl_beats(bl_r) - 9'h001;
      fp_nxt    = bl_r == BL_FULL;
      beat      = 1'b1;
    end else if (bmode_r != BU_NONE) begin
      if (stop_c || left_r == 9'h000) begin
        done_c    = 1'b1;
        bmode_nxt = BU_NONE;
      end else begin
        beat     = 1'b1;
        bcol_nxt = bcol_r + 8'h01;
        if (!fp_r) left_nxt = left_r - 9'h001;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      bmode_r <= BU_NONE;
      bbank_r <= 2'h0;
      bcol_r  <= 8'h00;
      left_r  <= 9'h000;
      fp_r    <= 1'b0;
    end else begin
      bmode_r <= bmode_nxt;
      bbank_r <= bbank_nxt;
      bcol_r  <= bcol_nxt;
      left_r  <= left_nxt;
      fp_r    <= fp_nxt;
    end
  end

  // The beat in a new command's cycle belongs to the new burst, so the
  // cut write's last beat is the one just before it.
  assign rbeat     = beat & (new_burst ? is_rd : bmode_r == BU_READ);
  assign wbeat     = beat & (new_burst ? is_wr
                                       : bmode_r == BU_WRITE);
  assign beat_addr = new_burst ? {i_ba, i_addr[7:0]} : {bbank_r, bcol_r};
  assign o_rd_req  = rbeat;
  assign o_rd_addr = beat_addr;

  // Read pipeline: data leaves read latency cycles after its beat, so a
  // read cut by a read still drains its queued beats.
  always_comb begin
    pv_nxt       = {pv_r[1:0], rbeat};
    pd_nxt[0]    = i_rd_data;
    pd_nxt[1]    = pd_r[0];
    pd_nxt[2]    = pd_r[1];
    dqm_d_nxt[0] = i_dqm;
    dqm_d_nxt[1] = dqm_d_r[0];
    if (is_wr) pv_nxt = 3'h0;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pv_r       <= 3'h0;
      pd_r[0]    <= 32'h0000_0000;
      pd_r[1]    <= 32'h0000_0000;
      pd_r[2]    <= 32'h0000_0000;
      dqm_d_r[0] <= 4'h0;
      dqm_d_r[1] <= 4'h0;
    end else begin
      pv_r       <= pv_nxt;
      pd_r[0]    <= pd_nxt[0];
      pd_r[1]    <= pd_nxt[1];
      pd_r[2]    <= pd_nxt[2];
      dqm_d_r[0] <= dqm_d_nxt[0];
      dqm_d_r[1] <= dqm_d_nxt[1];
    end
  end

  // Output mask follows the data mask by two cycles; the write's own
  // cycle releases the bus at once so the controller can drive it.
  assign out_idx = 2'(cl_r - 2'h1);
  assign o_dq    = pd_r[out_idx];
  assign o_dq_oe = pv_r[out_idx] & ~(&dqm_d_r[1]) & ~is_wr;
  assign o_self_refresh = sref_r;

  // Write beats queue for the storage side; a full queue shows as a
  // low ready, and a beat taken then is lost.
  sbi_fifo #(
    .W (WQ_W),
    .D (WQ_DEPTH)
  ) u_wq (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_valid (wbeat),
    .i_data  ({i_dqm, beat_addr, i_dq}),
    .o_ready (o_wbuf_ready),
    .o_valid (o_wq_valid),
    .o_data  (o_wq_data),
    .i_ready (i_wq_ready)
  );

  // Per-bank state machines
  sbi_bank_if bif [NBANK] ();

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    assign bif[b].act  = is_act & (i_ba == 2'(b));
    assign bif[b].rd   = is_rd & (i_ba == 2'(b));
    assign bif[b].wr   = is_wr & (i_ba == 2'(b));
    assign bif[b].ap   = i_addr[AP_BIT];
    assign bif[b].pre  = is_pre & (i_addr[AP_BIT] | i_ba == 2'(b));
    assign bif[b].done = done_c & (bbank_r == 2'(b));
    assign bif[b].intr = intr_c & (bbank_r == 2'(b));
    assign o_bank_idle[b] = bif[b].state == BK_IDLE;
    sbi_bank u_bank (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .bif     (bif[b])
    );
  end

  sequence s_sr_exit;
    sref_r ##1 !sref_r;
  endsequence

  sequence s_rd_kept;
    (cl_r == 2'h2 && rbeat) ##1 !is_wr;
  endsequence

  sequence s_rd_ap_cut;
    new_burst && bmode_r == BU_READ && bbank_r == 2'h0 && i_ba != 2'h0
      && bif[0].state == BK_RD_AP;
  endsequence

  sequence s_wr_ap_cut;
    new_burst && bmode_r == BU_WRITE && bbank_r == 2'h0 && i_ba != 2'h0
      && bif[0].state == BK_WR_AP;
  endsequence

  chk_xsr_gate_cmds: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    s_sr_exit |-> !live [*2])
    else $error("command taken during self refresh exit delay");

  chk_rd_latency_out: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    s_rd_kept |=> pv_r[1] && o_dq == $past(i_rd_data, 2))
    else $error("read data not out after read latency");

  chk_wr_cuts_read: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    is_wr |-> !o_dq_oe ##1 (pv_r == 3'h0))
    else $error("read output not cut by write");

  chk_bst_own_burst: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (is_bst && bmode_r != BU_NONE) |->
      done_c && !intr_c ##1 (bmode_r == BU_NONE))
    else $error("burst terminate did not end the running burst");

  chk_rd_ap_precharge: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    s_rd_ap_cut |-> ##RP_LAST (bif[0].state == BK_IDLE))
    else $error("cut auto-precharge read not idle in time");

  chk_wr_ap_recovery: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    s_wr_ap_cut |-> ##WR_HOLD (bif[0].state == BK_WR_AP)
      ##1 (bif[0].state == BK_IDLE))
    else $error("cut auto-precharge write recovery wrong");

  chk_rd_cuts_write: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (is_rd && bmode_r == BU_WRITE) |-> !wbeat ##1 (bmode_r == BU_READ))
    else $error("write data taken in cycle of interrupting read");

  chk_wr_cuts_write: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (is_wr && bmode_r == BU_WRITE && bbank_r != i_ba) |->
      wbeat && beat_addr[9:8] == i_ba)
    else $error("new write beat not routed to new bank");
endmodule : sbi_sdram_core
`default_nettype wire

//--- verification/sbi_ctrl_model.sv
// Controller and storage model facing the SDRAM core's pins.
// Assumes the bench calls its tasks and shares the core clock.
`timescale 1ns/1ps
`default_nettype none
module sbi_ctrl_model import sbi_pkg::*; (
  input  wire logic            i_clock,
  output logic                 o_cke,
  output logic                 o_cs_n,
  output logic      [2:0]      o_cmd,
  output logic      [1:0]      o_ba,
  output logic      [10:0]     o_addr,
  output logic      [3:0]      o_dqm,
  output logic      [31:0]     o_dq,
  input  wire logic [9:0]      i_rd_addr,
  output logic      [31:0]     o_rd_data,
  input  wire logic            i_wq_valid,
  input  wire logic [WQ_W-1:0] i_wq_data,
  output logic                 o_wq_ready
);
  logic            cke_next;
  logic            stall;
  logic            tick;
  logic [WQ_W-1:0] got[$];

  initial begin
    cke_next = 1'b1;
    stall    = 1'b0;
    tick     = 1'b0;
    o_cke    = 1'b1;
    o_cs_n   = 1'b1;
    o_cmd    = 3'h7;
    o_ba     = 2'h0;
    o_addr   = 11'h000;
    o_dqm    = 4'h0;
    o_dq     = 32'h0000_0000;
  end

  // Storage answers in the same cycle with a word naming its address
  assign o_rd_data  = {12'hA5C, 10'h000, i_rd_addr};
  // Drains at half rate so the queue backs up, or not at all if stalled
  assign o_wq_ready = !stall && tick;

  always @(posedge i_clock) begin
    tick <= ~tick;
    if (i_wq_valid && o_wq_ready) begin
      got.push_back(i_wq_data);
    end
  end

  // Only legal sequences, cke driven from cke_next with each command
  task automatic cmd(input logic [2:0] c, input logic [1:0] b,
                     input logic [10:0] a, input logic [31:0] d,
                     input logic [3:0] m);
    @(posedge i_clock);
    o_cke  <= cke_next;
    o_cs_n <= 1'b0;
    o_cmd  <= c;
    o_ba   <= b;
    o_addr <= a;
    o_dq   <= d;
    o_dqm  <= m;
  endtask : cmd

  // Released bank, address and data lines show the inverse of their last value; the mask drives 0
  task automatic idle(input int n);
    repeat (n) cmd(3'h7, ~o_ba, ~o_addr, ~o_dq, 4'h0);
  endtask : idle
endmodule : sbi_ctrl_model
`default_nettype wire

//--- verification/test_sbi_sdram_core.sv
// Self-checking bench for the four-bank SDRAM bank-state core.
// Assumes the controller model drives every command and storage input.
`timescale 1ns/1ps
`default_nettype none
module test_sbi_sdram_core import sbi_pkg::*; ;
  logic            clock;
  logic            nrst;
  logic            cke;
  logic            cs_n;
  logic [2:0]      cmd;
  logic [1:0]      ba;
  logic [10:0]     addr;
  logic [3:0]      dqm;
  logic [31:0]     dq_in;
  logic [31:0]     dq_out;
  logic            dq_oe;
  logic [9:0]      rd_addr;
  logic [31:0]     rd_data;
  logic            wbuf_ready;
  logic            wq_valid;
  logic [WQ_W-1:0] wq_data;
  logic            wq_ready;
  logic [3:0]      bank_idle;
  logic            self_ref;
  logic [9:0]      none[$];
  logic [WQ_W-1:0] exp_q[$];
  int unsigned     num_errors = 0;
  int unsigned     n_compared = 0;
  int unsigned     cyc        = 0;

  sbi_sdram_core DUT (
    .i_clock        (clock),
    .i_nrst         (nrst),
    .i_cke          (cke),
    .i_cs_n         (cs_n),
    .i_ras_n        (cmd[2]),
    .i_cas_n        (cmd[1]),
    .i_we_n         (cmd[0]),
    .i_ba           (ba),
    .i_addr         (addr),
    .i_dqm          (dqm),
    .i_dq           (dq_in),
    .o_dq           (dq_out),
    .o_dq_oe        (dq_oe),
    .o_rd_req       (),
    .o_rd_addr      (rd_addr),
    .i_rd_data      (rd_data),
    .o_wbuf_ready   (wbuf_ready),
    .o_wq_valid     (wq_valid),
    .o_wq_data      (wq_data),
    .i_wq_ready     (wq_ready),
    .o_bank_idle    (bank_idle),
    .o_self_refresh (self_ref)
  );

  sbi_ctrl_model M (
    .i_clock    (clock),
    .o_cke      (cke),
    .o_cs_n     (cs_n),
    .o_cmd      (cmd),
    .o_ba       (ba),
    .o_addr     (addr),
    .o_dqm      (dqm),
    .o_dq       (dq_in),
    .i_rd_addr  (rd_addr),
    .o_rd_data  (rd_data),
    .i_wq_valid (wq_valid),
    .i_wq_data  (wq_data),
    .o_wq_ready (wq_ready)
  );

  initial clock = 1'b0;
  always #25 clock = ~clock;

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic op(input logic [2:0] k, input logic [1:0] b,
                    input logic [10:0] a);
    M.cmd(k, b, a, ~M.o_dq, 4'h0);
  endtask : op

  task automatic wr(input logic [1:0] b, input logic [10:0] a,
                    input logic [31:0] d, input logic [3:0] m);
    M.cmd(CMD_WR, b, a, d, m);
    exp_q.push_back({m, b, a[7:0], d});
  endtask : wr

  // Words due two cycles after the first read command, then a quiet bus
  task automatic expect_rd(input logic [9:0] s[$]);
    repeat (3) @(posedge clock);
    foreach (s[i]) begin
      #1;
      chk(dq_oe, 1'b1);
      chk(dq_out, {12'hA5C, 10'h000, s[i]});
      @(posedge clock);
    end
    #1;
    chk(dq_oe, 1'b0);
  endtask : expect_rd

  task automatic drain;
    M.stall = 1'b0;
    for (int i = 0; i < 200 && M.got.size() < exp_q.size(); i++) begin
      @(posedge clock);
    end
    @(posedge clock);
    #1;
    chk(M.got.size(), exp_q.size());
    foreach (exp_q[i]) begin
      chk(M.got[i], exp_q[i]);
    end
    chk(wq_valid, 1'b0);
    exp_q.delete();
    M.got.delete();
  endtask : drain

  task automatic t_read;
    op(CMD_LMR, 2'h0, 11'h022);
    M.idle(2);
    op(CMD_ACT, 2'h0, 11'h123);
    op(CMD_ACT, 2'h1, 11'h045);
    M.idle(1);
    #1;
    chk(bank_idle, 4'hC);
    fork
      begin op(CMD_RD, 2'h0, 11'h0FE); M.idle(7); end
      expect_rd('{10'h0FE, 10'h0FF, 10'h000, 10'h001});
    join
    fork
      begin op(CMD_RD, 2'h0, 11'h010); op(CMD_RD, 2'h1, 11'h020);
        M.idle(7); end
      expect_rd('{10'h010, 10'h120, 10'h121, 10'h122, 10'h123});
    join
    fork
      begin op(CMD_RD, 2'h0, 11'h430); op(CMD_RD, 2'h1, 11'h040);
        M.idle(7); end
      expect_rd('{10'h030, 10'h140, 10'h141, 10'h142, 10'h143});
    join
    chk(bank_idle, 4'hD);
    $display("read interleave test done");
  endtask : t_read

  task automatic t_write;
    M.stall = 1'b1;
    op(CMD_ACT, 2'h0, 11'h010);
    M.idle(1);
    wr(2'h0, 11'h010, 32'hA0A0_0001, 4'h0);
    wr(2'h1, 11'h020, 32'hB0B0_0002, 4'h5);
    fork
      begin M.cmd(CMD_RD, 2'h0, 11'h030, 32'hDEAD_0003, 4'h0);
        M.idle(6); end
      expect_rd('{10'h030, 10'h031, 10'h032, 10'h033});
    join
    wr(2'h0, 11'h450, 32'hC0C0_0004, 4'h0);
    wr(2'h1, 11'h060, 32'hD0D0_0005, 4'h0);
    op(CMD_BST, 2'h1, 11'h000);
    #1;
    chk(bank_idle[0], 1'b0);
    M.idle(3);
    #1;
    chk(bank_idle, 4'hD);
    op(CMD_ACT, 2'h0, 11'h010);
    M.idle(1);
    wr(2'h0, 11'h470, 32'hE0E0_0006, 4'h0);
    fork
      begin op(CMD_RD, 2'h1, 11'h008); M.idle(6); end
      expect_rd('{10'h108, 10'h109, 10'h10A, 10'h10B});
    join
    chk(bank_idle, 4'hD);
    op(CMD_ACT, 2'h0, 11'h010);
    M.idle(1);
    fork
      begin op(CMD_RD, 2'h1, 11'h478); wr(2'h0, 11'h088, 32'hF0F0_0007,
        4'h0); op(CMD_BST, 2'h0, 11'h000); M.idle(4); end
      expect_rd(none);
    join
    chk(bank_idle, 4'hE);
    drain();
    $display("write interleave test done");
  endtask : t_write

  task automatic t_power;
    op(CMD_PRE, 2'h0, 11'h400);
    M.idle(2);
    #1;
    chk(bank_idle, 4'hF);
    M.cke_next = 1'b0;
    op(CMD_REF, 2'h0, 11'h000);
    M.idle(3);
    #1;
    chk(self_ref, 1'b1);
    M.cke_next = 1'b1;
    M.idle(1);
    op(CMD_ACT, 2'h2, 11'h001);
    M.idle(3);
    #1;
    chk(bank_idle, 4'hF);
    chk(self_ref, 1'b0);
    op(CMD_ACT, 2'h2, 11'h001);
    M.cke_next = 1'b0;
    M.idle(1);
    M.cke_next = 1'b1;
    op(CMD_ACT, 2'h3, 11'h001);
    M.idle(1);
    #1;
    chk(bank_idle, 4'hB);
    $display("clock enable test done");
  endtask : t_power

  // Full-page write fills the stalled queue exactly, then a terminate ends it
  task automatic t_fill;
    op(CMD_PRE, 2'h0, 11'h400);
    M.idle(2);
    op(CMD_LMR, 2'h0, 11'h027);
    M.idle(2);
    op(CMD_ACT, 2'h3, 11'h7FF);
    M.idle(1);
    M.stall = 1'b1;
    wr(2'h3, 11'h0F0, 32'h0000_0000, 4'h0);
    for (int i = 1; i < 32; i++) begin
      M.cmd(3'h7, 2'h0, 11'h000, 32'(i), 4'h0);
      exp_q.push_back({4'h0, 2'h3, 8'(8'hF0 + i), 32'(i)});
    end
    op(CMD_BST, 2'h3, 11'h000);
    #1;
    chk(wbuf_ready, 1'b0);
    M.idle(2);
    drain();
    $display("queue fill test done");
  endtask : t_fill

  initial begin
    nrst = 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    chk(bank_idle, 4'hF);
    chk(dq_oe, 1'b0);
    chk(wq_valid, 1'b0);
    chk(wbuf_ready, 1'b1);
    chk(self_ref, 1'b0);
    $display("reset test done");
    M.idle(2);
    t_read();
    t_write();
    t_power();
    t_fill();
    summarize();
  end
endmodule : test_sbi_sdram_core
`default_nettype wire
